/* File: include/cmsc_defines.svh */
// Notes on behaviour
// - Oscillator-clocked run mode takes the bus clock from the oscillator clock.
// - PLL stays running to qualify the oscillator; software keeps it valid.
// - Wait mode is handled exactly as run mode; no clock changes.
// - Stop mode is entered only on the core's stop instruction.
// - In stop the regulator goes to reduced power; periodic timer stays.
// - In stop PLL, 1 MHz reference, core, bus and debug clocks are off.
// - Pseudo stop needs pseudo-stop and oscillator enable set; else full stop.
// - Full stop disables the external crystal oscillator.
// - Full stop, upper watchdog select zero: watchdog and tick counters halt.
// - Wake from that case: PLL select set, watchdog lower and tick select cleared.
// - Full stop, upper select one: watchdog runs on RC clock, tick halts.
// - Wake from that case: PLL select set, watchdog on RC, tick on RC.
`ifndef CMSC_DEFINES_SVH
`define CMSC_DEFINES_SVH

// ==========================================================
// Register map
`define CMSC_CTRL_ADDR     12'h000
`define CMSC_STAT_ADDR     12'h004

// ==========================================================
// Control fields
`define CMSC_CTRL_W        6
`define CMSC_OSC_EN        0
`define CMSC_PLL_SEL       1
`define CMSC_PSTOP         2
`define CMSC_WDOG_SEL_LO   3
`define CMSC_WDOG_SEL_HI   4
`define CMSC_TICK_SEL      5
`define CMSC_CTRL_RST      6'h02

// ==========================================================
// Status fields
`define CMSC_ST_OSC_UP     0
`define CMSC_ST_PLL_LOCK   1
`define CMSC_ST_WAIT       2
`define CMSC_ST_BUS_OSC    3
`define CMSC_ST_STATE_LSB  4

// ==========================================================
// Timing
`define CMSC_OSC_QUAL_CYC  16'h0100

`endif

/* File: include/cmsc_pkg.sv */
package cmsc_pkg;

  // ==========================================================
  // Power state, one-hot
  typedef enum logic [3:0] {
    CMSC_ST_RUN    = 4'b0001,
    CMSC_ST_FULL   = 4'b0010,
    CMSC_ST_PSEUDO = 4'b0100,
    CMSC_ST_WAKE   = 4'b1000
  } cmsc_state_e;

  // ==========================================================
  // Main block state
  typedef struct packed {
    cmsc_state_e  st;
    logic [5:0]   ctrl;
    logic         wr_pend;
    logic [11:0]  wr_addr;
    logic [31:0]  hrdata;
  } cmsc_regs_s;

  // ==========================================================
  // Qualifier state
  typedef struct packed {
    logic [15:0]  cnt;
    logic         up;
  } cmsc_qual_s;

endpackage : cmsc_pkg

/* File: verilog/cmsc_osc_qual.sv */
`timescale 1ns/1ps
`include "cmsc_defines.svh"

module cmsc_osc_qual
  import cmsc_pkg::*;
(
  input  wire logic  hclk,
  input  wire logic  hresetn,
  input  wire logic  osc_on,
  input  wire logic  osc_ready,
  input  wire logic  pll_running,
  output logic       osc_up
);

  cmsc_qual_s q_r;
  cmsc_qual_s q_nxt;

  // ==========================================================
  // Qualification counter
  always_comb begin
    q_nxt = q_r;
    if (!osc_on || !osc_ready || !pll_running) begin
      // Any glitch restarts the count; the flag drops with it
      q_nxt.cnt = 16'h0000;
      q_nxt.up  = 1'b0;
    end else if (q_r.cnt == `CMSC_OSC_QUAL_CYC) begin
      q_nxt.up  = 1'b1;
    end else begin
      q_nxt.cnt = q_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign osc_up = q_r.up;

endmodule : cmsc_osc_qual

/* File: verilog/cmsc_clock_ctrl.sv */
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "cmsc_defines.svh"

module cmsc_clock_ctrl
  import cmsc_pkg::*;
(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  input  wire logic         cpu_stop,
  input  wire logic         cpu_wait,
  input  wire logic         wake_event,
  input  wire logic         osc_ready,
  input  wire logic         pll_lock,
  output logic              bus_clk_from_osc,
  output logic              pll_enable,
  output logic              one_mhz_internal_reference_enable,
  output logic              xtal_osc_enable,
  output logic              core_clk_enable,
  output logic              bus_clk_enable,
  output logic              debug_clk_enable,
  output logic              regulator_reduced_power,
  output logic              periodic_timer_enable,
  output logic              watchdog_run,
  output logic              watchdog_on_rc,
  output logic              tick_run,
  output logic              tick_on_osc,
  output logic              stop_active,
  output logic              pseudo_stop_active
);

  cmsc_regs_s r_r;
  cmsc_regs_s r_nxt;
  logic       oscillator_up_flag;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] read_word(
    input logic [11:0]  addr,
    input logic [5:0]   ctrl,
    input logic [3:0]   st,
    input logic         osc_up,
    input logic         lock,
    input logic         wt,
    input logic         bus_osc
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    if (addr == `CMSC_CTRL_ADDR) begin
      w[`CMSC_CTRL_W-1:0] = ctrl;
    end else if (addr == `CMSC_STAT_ADDR) begin
      w[`CMSC_ST_OSC_UP]   = osc_up;
      w[`CMSC_ST_PLL_LOCK] = lock;
      w[`CMSC_ST_WAIT]     = wt;
      w[`CMSC_ST_BUS_OSC]  = bus_osc;
      w[`CMSC_ST_STATE_LSB +: 4] = st;
    end
    return w;
  endfunction : read_word

  function automatic logic is_ctrl(input logic [11:0] addr);
    return addr == `CMSC_CTRL_ADDR;
  endfunction : is_ctrl

  // ==========================================================
  // Oscillator qualification
  cmsc_osc_qual u_qual (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .osc_on      (xtal_osc_enable),
    .osc_ready   (osc_ready),
    .pll_running (pll_enable),
    .osc_up      (oscillator_up_flag)
  );

  // ==========================================================
  // Next state
  always_comb begin
    logic        addr_ph;
    logic [5:0]  c;
    logic        bus_osc;
    addr_ph = 1'b0;
    c       = 6'h00;
    bus_osc = 1'b0;
    r_nxt   = r_r;

    // Data phase of a write lands here
    c = r_r.ctrl;
    if (r_r.wr_pend && is_ctrl(r_r.wr_addr)) begin
      c = hwdata[`CMSC_CTRL_W-1:0];
    end

    // Address phase capture, zero wait states
    addr_ph = hsel && hready && htrans[1];
    r_nxt.wr_pend = addr_ph && hwrite;
    if (addr_ph) begin
      r_nxt.wr_addr = haddr[11:0];
    end

    // Power state sequencing
    case (r_r.st)
      CMSC_ST_RUN: begin
        // wait is run
        // cpu_wait only shows in status; clocks are left untouched
        // stop instruction only
        if (cpu_stop) begin
          if (c[`CMSC_PSTOP] && c[`CMSC_OSC_EN]) begin
            r_nxt.st = CMSC_ST_PSEUDO;
          end else begin
            r_nxt.st = CMSC_ST_FULL;
          end
        end
      end
      CMSC_ST_FULL: begin
        if (wake_event) begin
          r_nxt.st = CMSC_ST_WAKE;
          c[`CMSC_PLL_SEL]     = 1'b1;
          c[`CMSC_TICK_SEL]    = 1'b0;
          c[`CMSC_WDOG_SEL_LO] = 1'b0;
        end
      end
      CMSC_ST_PSEUDO: begin
        // Selections kept; oscillator never stopped
        if (wake_event) begin
          r_nxt.st = CMSC_ST_WAKE;
        end
      end
      CMSC_ST_WAKE: begin
        // Clocks come back only after the PLL has relocked
        if (pll_lock) begin
          r_nxt.st = CMSC_ST_RUN;
        end
      end
      default: begin
        r_nxt.st = CMSC_ST_RUN;
      end
    endcase
    r_nxt.ctrl = c;

    bus_osc = !c[`CMSC_PLL_SEL] && oscillator_up_flag && pll_enable;

    // Forwarded so a read right after a write sees new data
    if (addr_ph && !hwrite) begin
      r_nxt.hrdata = read_word(haddr[11:0], c, r_nxt.st,
                               oscillator_up_flag, pll_lock,
                               cpu_wait, bus_osc);
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_r.st      <= CMSC_ST_RUN;
      r_r.ctrl    <= `CMSC_CTRL_RST;
      r_r.wr_pend <= 1'b0;
      r_r.wr_addr <= 12'h000;
      r_r.hrdata  <= 32'h0000_0000;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ==========================================================
  // Bus answer
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = r_r.hrdata;

  // ==========================================================
  // Clock and power outputs
  logic in_stop;
  logic in_full;
  logic in_pseudo;
  assign in_full   = r_r.st == CMSC_ST_FULL;
  assign in_pseudo = r_r.st == CMSC_ST_PSEUDO;
  assign in_stop   = in_full || in_pseudo;

  assign stop_active        = in_stop;
  assign pseudo_stop_active = in_pseudo;

  // bus clock source
  // Up flag lags stop entry by one cycle, so the PLL gates it too
  assign bus_clk_from_osc = !r_r.ctrl[`CMSC_PLL_SEL] && oscillator_up_flag &&
                            pll_enable;

  assign pll_enable   = !in_stop;
  assign one_mhz_internal_reference_enable = !in_stop;

  // gate core, bus, debug
  // Wake keeps them gated too, so no clock runs from an unlocked PLL
  logic [2:0] gate_on;
  genvar      g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_gate
      assign gate_on[g] = r_r.st == CMSC_ST_RUN;
    end
  endgenerate
  assign core_clk_enable  = gate_on[0];
  assign bus_clk_enable   = gate_on[1];
  assign debug_clk_enable = gate_on[2];

  assign regulator_reduced_power = in_stop;
  assign periodic_timer_enable   = 1'b1;

  assign xtal_osc_enable = r_r.ctrl[`CMSC_OSC_EN] && !in_full;

  assign watchdog_on_rc = r_r.ctrl[`CMSC_WDOG_SEL_HI];

  // only watchdog survives full stop, and only with upper select one
  // Pseudo stop keeps counters that run on the still-live oscillator
  assign watchdog_run = !in_full || r_r.ctrl[`CMSC_WDOG_SEL_HI];
  assign tick_run     = !in_full &&
                        (!in_pseudo || r_r.ctrl[`CMSC_TICK_SEL]);

  assign tick_on_osc = r_r.ctrl[`CMSC_TICK_SEL];

endmodule : cmsc_clock_ctrl

/* File: testbench/cmsc_clock_ctrl_props.sv */
`timescale 1ns/1ps
module cmsc_clock_ctrl_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic cpu_stop,
  input wire logic cpu_wait,
  input wire logic bus_clk_from_osc,
  input wire logic pll_enable,
  input wire logic one_mhz_internal_reference_enable,
  input wire logic xtal_osc_enable,
  input wire logic core_clk_enable,
  input wire logic bus_clk_enable,
  input wire logic debug_clk_enable,
  input wire logic regulator_reduced_power,
  input wire logic periodic_timer_enable,
  input wire logic watchdog_run,
  input wire logic watchdog_on_rc,
  input wire logic tick_run,
  input wire logic stop_active,
  input wire logic pseudo_stop_active
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // Stop and wake steps
  sequence s_full;
    stop_active && !pseudo_stop_active;
  endsequence
  sequence s_wake;
    stop_active ##1 !stop_active;
  endsequence
  a_stop_gate: assert property (
    stop_active |-> !(core_clk_enable || bus_clk_enable ||
      debug_clk_enable || pll_enable || one_mhz_internal_reference_enable))
    else $error("clock left running in stop");
  a_stop_power: assert property (
    stop_active |-> regulator_reduced_power && periodic_timer_enable)
    else $error("regulator or periodic timer wrong in stop");
  a_stop_cause: assert property (
    $rose(stop_active) |-> $past(cpu_stop))
    else $error("stop entered without stop instruction");
  a_full_xtal: assert property (
    s_full |-> !xtal_osc_enable)
    else $error("crystal on in full stop");
  a_pseudo_xtal: assert property (
    pseudo_stop_active |-> stop_active && xtal_osc_enable)
    else $error("crystal off in pseudo stop");
  a_full_counters: assert property (
    s_full |-> !tick_run && watchdog_run == watchdog_on_rc)
    else $error("counter clocks wrong in full stop");
  a_wake_pll: assert property (
    s_wake |-> pll_enable && !bus_clk_from_osc)
    else $error("wake not on pll clock");
  a_osc_pll: assert property (
    bus_clk_from_osc |-> pll_enable)
    else $error("pll off while bus on oscillator");
  a_wait_same: assert property (
    $changed(cpu_wait) && !hsel && !$past(hsel) && !cpu_stop |=>
      $stable({core_clk_enable, pll_enable, xtal_osc_enable}))
    else $error("wait changed clocks");
endmodule : cmsc_clock_ctrl_props

bind cmsc_clock_ctrl cmsc_clock_ctrl_props u_props (.*);

/* File: testbench/cmsc_core_model.sv */
`timescale 1ns/1ps
module cmsc_core_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic stop_req,
  input wire logic wait_req,
  output logic     cpu_stop,
  output logic     cpu_wait
);
  // ==========================================================
  // Core side: one pulse per stop instruction
  // stop only on instruction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_stop <= 1'b0;
      cpu_wait <= 1'b0;
    end else begin
      cpu_stop <= stop_req && !cpu_stop;
      cpu_wait <= wait_req;
    end
  end
endmodule : cmsc_core_model

/* File: testbench/cmsc_clock_ctrl_tb.sv */
`timescale 1ns/1ps
module cmsc_clock_ctrl_tb;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        cpu_stop, cpu_wait, wake_event, osc_ready, pll_lock;
  logic        stop_req, wait_req, bus_clk_from_osc, pll_enable;
  logic        one_mhz_internal_reference_enable, xtal_osc_enable, core_clk_enable;
  logic        bus_clk_enable, debug_clk_enable, regulator_reduced_power;
  logic        periodic_timer_enable, watchdog_run, watchdog_on_rc;
  logic        tick_run, tick_on_osc, stop_active, pseudo_stop_active;
  int          n_mismatch, n_checks;
  assign hready = hreadyout;
  cmsc_clock_ctrl dut (.*);
  cmsc_core_model u_core (.*);
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic chk(input string n, input logic [31:0] e, s);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Holds each phase until hready is seen high
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic t_reset;
    bus(1'b0, 12'h000, 32'h0);
    chk("ctrl", 32'h02, q);
    chk("hresp", 32'h0, {31'h0, hresp});
    bus(1'b0, 12'h004, 32'h0);
    chk("state", 32'h10, q & 32'hf0);
    bus(1'b0, 12'h008, 32'h0);
    chk("unmapped", 32'h0, q);
  endtask : t_reset
  task automatic t_osc;
    bus(1'b1, 12'h000, 32'h03);
    for (int i = 0; i < 300 && q[0] !== 1'b1; i++) bus(1'b0, 12'h004, 0);
    chk("osc_up", 32'h1, {31'h0, q[0]});
    bus(1'b1, 12'h000, 32'h01);
    wait_req <= 1'b1;
    repeat (3) @(posedge hclk);
    #1 chk("bus_osc", 32'h1, {31'h0, bus_clk_from_osc});
    chk("core_clk", 32'h1, {31'h0, core_clk_enable});
    @(posedge hclk);
    bus(1'b0, 12'h004, 32'h0);
    chk("wait", 32'h1, {31'h0, q[2]});
    wait_req <= 1'b0;
  endtask : t_osc
  task automatic t_stop(input logic [31:0] c, input logic ps);
    bus(1'b1, 12'h000, c);
    stop_req <= 1'b1;
    @(posedge hclk);
    stop_req <= 1'b0;
    repeat (3) @(posedge hclk);
    #1 chk("stop", {31'h0, ps}, {31'h0, pseudo_stop_active});
    chk("stopped", 32'h1, {31'h0, stop_active});
    chk("xtal", {31'h0, ps}, {31'h0, xtal_osc_enable});
    chk("wdog", {31'h0, ps | c[4]}, {31'h0, watchdog_run});
    chk("tick", {31'h0, ps & c[5]}, {31'h0, tick_run});
    @(posedge hclk);
    wake_event <= 1'b1;
    pll_lock <= 1'b0;
    @(posedge hclk);
    wake_event <= 1'b0;
    repeat (3) @(posedge hclk);
    #1 chk("held", 32'h0, {31'h0, core_clk_enable});
    chk("pll_on", 32'h1, {31'h0, pll_enable});
    @(posedge hclk);
    pll_lock <= 1'b1;
    repeat (3) @(posedge hclk);
    #1 chk("woken", 32'h1, {31'h0, core_clk_enable});
    chk("tick_src", {31'h0, ps & c[5]}, {31'h0, tick_on_osc});
    @(posedge hclk);
    bus(1'b0, 12'h000, 32'h0);
    chk("ctrl_wake", ps ? c : (c | 32'h2) & ~32'h28, q);
  endtask : t_stop
  task automatic tally_and_finish;
    if (n_mismatch == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  // Watchdog: the whole run needs about 340 cycles
  initial begin
    #50000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
    {stop_req, wait_req, wake_event} = '0;
    {osc_ready, pll_lock} = 2'b11;
    hsize = 3'h2;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_osc();
    t_stop(32'h25, 1'b1);
    t_stop(32'h04, 1'b0);
    t_stop(32'h39, 1'b0);
    tally_and_finish();
  end
endmodule : cmsc_clock_ctrl_tb
